/* File: rtl/scsf_socket.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scsf_params.svh"
module scsf_socket
(
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire scsf_pkg::scsf_host_t host,
    input  wire scsf_pkg::scsf_net_t  net,
    input  wire logic [15:0]        retryPeriod,
    input  wire logic [7:0]         retryLimit,
    output logic [7:0]              socketCommand,
    output logic [7:0]              socketState,
    output logic [7:0]              socketEventFlags,
    output logic [15:0]             txReadPointer,
    output logic [15:0]             txFreeSize,
    output logic                    sendSyn,
    output logic                    sendSynAck,
    output logic                    sendFin,
    output logic                    arpRequest,
    output logic                    segValid,
    output logic [15:0]             segLength
);
    import scsf_pkg::*;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [7:0]  state;
        logic [7:0]  flags;
        logic [15:0] rdPtr;
        logic [15:0] freeSize;
        logic [15:0] remain;
        scsf_seg_e_t seg;
        logic        syn;
        logic        synAck;
        logic        fin;
        logic        arp;
        logic        segValid;
        logic [15:0] segLen;
        logic        resolved;
    } scsf_sock_t;

    scsf_sock_t st_ff;
    scsf_sock_t nxt_st;
    logic       tmrExpired;
    logic       tmrRun;
    logic       tmrKick;
    logic       isBroadcast;
    logic [7:0] setFlags;

    // ==========================================================
    // Retry timer
    // ==========================================================
    assign tmrRun = (st_ff.state == `SCSF_ST_SYNSENT) || (st_ff.seg == SEG_WAIT)
                  || (st_ff.seg == SEG_ARP) || (st_ff.state == `SCSF_ST_HSRECV)
                  || (st_ff.fin);
    assign tmrKick = net.ackIn || net.synAckIn || net.arpDone;

    scsf_retry_timer u_timer
    (
        .clk         (clk),
        .resetn      (resetn),
        .run         (tmrRun),
        .kick        (tmrKick),
        .retryPeriod (retryPeriod),
        .retryLimit  (retryLimit),
        .expired     (tmrExpired)
    );

    // Broadcast if all-ones or subnet-directed
    assign isBroadcast = (host.destIp == `SCSF_ALL_ONES_IP)
                       || (host.destIp == (host.localIp | ~host.subnetMask));

    // ==========================================================
    // Command and state flow
    // ==========================================================
    always_comb
    begin
        nxt_st = st_ff;
        setFlags = `SCSF_FLAGS_ZERO;
        nxt_st.syn = 1'b0;
        nxt_st.synAck = 1'b0;
        nxt_st.arp = 1'b0;
        nxt_st.segValid = 1'b0;
        if (host.commandWe && st_ff.cmd == `SCSF_CMD_NONE)
        begin
            nxt_st.cmd = host.command;
        end
        // Commands are accepted in one cycle, then read back as zero
        if (st_ff.cmd != `SCSF_CMD_NONE)
        begin
            nxt_st.cmd = `SCSF_CMD_NONE;
            unique case (st_ff.cmd)
                `SCSF_CMD_OPEN:
                begin
                    if (host.protocol == `SCSF_PROTO_UDP)
                        nxt_st.state = `SCSF_ST_DGRAM;
                    else if (host.protocol == `SCSF_PROTO_TCP)
                        nxt_st.state = `SCSF_ST_OPENED;
                    nxt_st.rdPtr = host.txWritePointer;
                end
                `SCSF_CMD_LISTEN:
                    if (st_ff.state == `SCSF_ST_OPENED)
                        nxt_st.state = `SCSF_ST_AWAIT;
                `SCSF_CMD_CONNECT:
                    if (st_ff.state == `SCSF_ST_OPENED)
                    begin
                        nxt_st.syn = 1'b1;
                        nxt_st.state = `SCSF_ST_SYNSENT;
                    end
                `SCSF_CMD_TEARDOWN_COMMAND_OR_FLAG:
                    nxt_st.fin = 1'b1;
                `SCSF_CMD_CLOSE:
                begin
                    nxt_st.state = `SCSF_ST_SHUT;
                    nxt_st.seg = SEG_IDLE;
                    nxt_st.fin = 1'b0;
                    setFlags[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG] = 1'b1;
                end
                `SCSF_CMD_SEND:
                begin
                    // Length is the write pointer minus the read pointer
                    nxt_st.remain = host.txWritePointer - st_ff.rdPtr;
                    nxt_st.resolved = 1'b0;
                    nxt_st.seg = SEG_SEND;
                    if (st_ff.state == `SCSF_ST_DGRAM && !isBroadcast)
                    begin
                        nxt_st.seg = SEG_ARP;
                        nxt_st.arp = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Segmentation of send data
        unique case (st_ff.seg)
            SEG_IDLE:
            begin
            end
            SEG_ARP:
                if (net.arpDone)
                    nxt_st.seg = SEG_SEND;
                else if (net.arpFail || tmrExpired)
                begin
                    setFlags[`SCSF_EV_TIMEOUT] = 1'b1;
                    nxt_st.seg = SEG_IDLE;
                end
            SEG_SEND:
                if (net.wireReady)
                begin
                    nxt_st.segLen = (st_ff.remain > host.mss) ? host.mss : st_ff.remain;
                    nxt_st.segValid = (st_ff.remain != `SCSF_PTR_ZERO);
                    nxt_st.seg = (st_ff.remain == `SCSF_PTR_ZERO) ? SEG_DONE : SEG_WAIT;
                end
            SEG_WAIT:
                if (net.ackIn || st_ff.state == `SCSF_ST_DGRAM)
                begin
                    nxt_st.rdPtr = st_ff.rdPtr + st_ff.segLen;
                    nxt_st.remain = st_ff.remain - st_ff.segLen;
                    nxt_st.seg = SEG_SEND;
                end
                else if (tmrExpired)
                begin
                    nxt_st.seg = SEG_IDLE;
                end
            SEG_DONE:
            begin
                setFlags[`SCSF_EV_SENDOK] = 1'b1;
                nxt_st.seg = SEG_IDLE;
            end
        endcase
        // Network events
        if (st_ff.state == `SCSF_ST_AWAIT && net.synIn)
        begin
            nxt_st.state = `SCSF_ST_HSRECV;
            nxt_st.synAck = 1'b1;
        end
        else if (st_ff.state == `SCSF_ST_HSRECV && net.ackIn)
        begin
            nxt_st.state = `SCSF_ST_ESTAB;
            setFlags[`SCSF_EV_CON] = 1'b1;
        end
        else if (st_ff.state == `SCSF_ST_SYNSENT && net.synAckIn)
        begin
            nxt_st.state = `SCSF_ST_ESTAB;
            setFlags[`SCSF_EV_CON] = 1'b1;
        end
        if (st_ff.fin && net.ackIn)
        begin
            nxt_st.fin = 1'b0;
            nxt_st.state = `SCSF_ST_SHUT;
            setFlags[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG] = 1'b1;
        end
        else if (net.finIn && st_ff.state == `SCSF_ST_ESTAB)
        begin
            nxt_st.state = `SCSF_ST_PEERCLOSE;
            setFlags[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG] = 1'b1;
        end
        if (tmrExpired && st_ff.state != `SCSF_ST_DGRAM && st_ff.state != `SCSF_ST_SHUT)
        begin
            nxt_st.state = `SCSF_ST_SHUT;
            nxt_st.seg = SEG_IDLE;
            nxt_st.fin = 1'b0;
            setFlags[`SCSF_EV_TIMEOUT] = 1'b1;
        end
        // Set beats clear in the same cycle
        nxt_st.flags = (st_ff.flags & ~host.eventClear) | setFlags;
        nxt_st.freeSize = `SCSF_TX_SIZE - (host.txWritePointer - nxt_st.rdPtr);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_ff <= '0;
            st_ff.freeSize <= `SCSF_TX_SIZE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign socketCommand = st_ff.cmd;
    assign socketState = st_ff.state;
    assign socketEventFlags = st_ff.flags;
    assign txReadPointer = st_ff.rdPtr;
    assign txFreeSize = st_ff.freeSize;
    assign sendSyn = st_ff.syn;
    assign sendSynAck = st_ff.synAck;
    assign sendFin = st_ff.fin;
    assign arpRequest = st_ff.arp;
    assign segValid = st_ff.segValid;
    assign segLength = st_ff.segLen;

    // ==========================================================
    // Checks
    // ==========================================================
    a_cmd_clears: assert property (@(posedge clk) disable iff (!resetn)
        (socketCommand != `SCSF_CMD_NONE) |=> (socketCommand == `SCSF_CMD_NONE))
        else $error("command not cleared");
    a_seg_max_mss: assert property (@(posedge clk) disable iff (!resetn)
        segValid |-> (segLength <= $past(host.mss)))
        else $error("segment exceeds mss");
    a_fin_closing: assert property (@(posedge clk) disable iff (!resetn)
        (net.finIn && socketState == `SCSF_ST_ESTAB && !sendFin && !tmrExpired)
        |=> (socketState == `SCSF_ST_PEERCLOSE) && socketEventFlags[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG])
        else $error("fin not handled");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
        (socketEventFlags[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG] && !host.eventClear[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG])
        |=> socketEventFlags[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG])
        else $error("flag dropped without clear");
    a_close_shut: assert property (@(posedge clk) disable iff (!resetn)
        (socketCommand == `SCSF_CMD_CLOSE) |=> (socketState == `SCSF_ST_SHUT)
        && socketEventFlags[`SCSF_EV_TEARDOWN_COMMAND_OR_FLAG])
        else $error("close did not shut");
    a_timeout_shut: assert property (@(posedge clk) disable iff (!resetn)
        (tmrExpired && socketState == `SCSF_ST_SYNSENT)
        |=> (socketState == `SCSF_ST_SHUT) && socketEventFlags[`SCSF_EV_TIMEOUT])
        else $error("timeout did not shut");
    a_connect_syn: assert property (@(posedge clk) disable iff (!resetn)
        (socketCommand == `SCSF_CMD_CONNECT && socketState == `SCSF_ST_OPENED)
        |=> sendSyn)
        else $error("no syn on connect");
    a_bcast_no_arp: assert property (@(posedge clk) disable iff (!resetn)
        (socketCommand == `SCSF_CMD_SEND && isBroadcast) |=> !arpRequest)
        else $error("arp on broadcast");
    a_udp_open: assert property (@(posedge clk) disable iff (!resetn)
        (socketCommand == `SCSF_CMD_OPEN && host.protocol == `SCSF_PROTO_UDP)
        |=> (socketState == `SCSF_ST_DGRAM))
        else $error("udp open failed");
    a_listen_syn: assert property (@(posedge clk) disable iff (!resetn)
        (socketState == `SCSF_ST_AWAIT && net.synIn && !tmrExpired
            && socketCommand == `SCSF_CMD_NONE)
        |=> sendSynAck && (socketState == `SCSF_ST_HSRECV))
        else $error("no syn-ack");
    a_rdptr_step: assert property (@(posedge clk) disable iff (!resetn)
        ($past(st_ff.seg) == SEG_WAIT && st_ff.seg == SEG_SEND)
        |-> (txReadPointer == $past(txReadPointer) + $past(segLength)))
        else $error("read pointer step wrong");
endmodule : scsf_socket
`default_nettype wire

/* File: rtl/scsf_params.svh */
`ifndef SCSF_PARAMS_SVH
`define SCSF_PARAMS_SVH
// Command codes
`define SCSF_CMD_NONE      8'h00
`define SCSF_CMD_OPEN      8'h01
`define SCSF_CMD_LISTEN    8'h02
`define SCSF_CMD_CONNECT   8'h04
`define SCSF_CMD_TEARDOWN_COMMAND_OR_FLAG    8'h08
`define SCSF_CMD_CLOSE     8'h10
`define SCSF_CMD_SEND      8'h20
// Socket state codes
`define SCSF_ST_SHUT       8'h00
`define SCSF_ST_OPENED     8'h13
`define SCSF_ST_AWAIT      8'h14
`define SCSF_ST_ESTAB      8'h17
`define SCSF_ST_PEERCLOSE  8'h1C
`define SCSF_ST_DGRAM      8'h22
`define SCSF_ST_HSRECV     8'h15
`define SCSF_ST_SYNSENT    8'h12
// Protocol select
`define SCSF_PROTO_TCP     4'h1
`define SCSF_PROTO_UDP     4'h2
// Event flag bit positions
`define SCSF_EV_CON        0
`define SCSF_EV_TEARDOWN_COMMAND_OR_FLAG     1
`define SCSF_EV_TIMEOUT    3
`define SCSF_EV_SENDOK     4
// Buffer size (bytes) and zero and all-ones constants
`define SCSF_TX_SIZE       16'h0800
`define SCSF_PTR_ZERO      16'h0000
`define SCSF_FLAGS_ZERO    8'h00
`define SCSF_ALL_ONES_IP   32'hFFFF_FFFF
// Retry period unit in ns (100 us), one cycle is 5 ns
`define SCSF_RETRY_UNIT_NS 100000
`define SCSF_CLK_NS        5
`define SCSF_RETRY_UNIT_CYC (`SCSF_RETRY_UNIT_NS / `SCSF_CLK_NS)
`endif

/* File: rtl/scsf_pkg.sv */
`default_nettype none
package scsf_pkg;
    typedef struct packed {
        logic [7:0]  command;
        logic        commandWe;
        logic [3:0]  protocol;
        logic [15:0] txWritePointer;
        logic [15:0] mss;
        logic [7:0]  eventClear;
        logic [31:0] destIp;
        logic [31:0] localIp;
        logic [31:0] subnetMask;
    } scsf_host_t;

    typedef struct packed {
        logic synIn;
        logic synAckIn;
        logic finIn;
        logic ackIn;
        logic arpDone;
        logic arpFail;
        logic wireReady;
    } scsf_net_t;

    typedef enum logic [2:0] {
        SEG_IDLE = 3'b000,
        SEG_ARP  = 3'b001,
        SEG_SEND = 3'b011,
        SEG_WAIT = 3'b010,
        SEG_DONE = 3'b110
    } scsf_seg_e_t;
endpackage : scsf_pkg
`default_nettype wire

/* File: rtl/scsf_retry_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scsf_params.svh"
module scsf_retry_timer
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        run,
    input  wire logic        kick,
    input  wire logic [15:0] retryPeriod,
    input  wire logic [7:0]  retryLimit,
    output logic             expired
);
    import scsf_pkg::*;
    typedef struct packed {
        logic [15:0] unitCnt;
        logic [15:0] periodCnt;
        logic [7:0]  tries;
        logic        expired;
    } scsf_tmr_t;
    localparam logic [15:0] UNIT_MAX = 16'(`SCSF_RETRY_UNIT_CYC - 1);
    scsf_tmr_t st_ff;
    scsf_tmr_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.expired = 1'b0;
        if (!run || kick)
        begin
            nxt_st.unitCnt = 16'h0000;
            nxt_st.periodCnt = 16'h0000;
            nxt_st.tries = 8'h00;
        end
        else if (st_ff.unitCnt != UNIT_MAX)
        begin
            nxt_st.unitCnt = st_ff.unitCnt + 16'h0001;
        end
        else
        begin
            nxt_st.unitCnt = 16'h0000;
            if (st_ff.periodCnt + 16'h0001 < retryPeriod)
            begin
                nxt_st.periodCnt = st_ff.periodCnt + 16'h0001;
            end
            else
            begin
                // Period lapsed: one retry used; past the limit is final expiry
                nxt_st.periodCnt = 16'h0000;
                if (st_ff.tries >= retryLimit)
                begin
                    nxt_st.expired = 1'b1;
                    nxt_st.tries = 8'h00;
                end
                else
                begin
                    nxt_st.tries = st_ff.tries + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    assign expired = st_ff.expired;
endmodule : scsf_retry_timer
`default_nettype wire

/* File: bench/scsf_net_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Network far side: acks, resolution, handshake
// ==========================================
module scsf_net_peer
(
    input  wire logic                clk,
    input  wire logic                segValid,
    input  wire logic                arpRequest,
    input  wire logic                sendSyn,
    input  wire logic                sendSynAck,
    input  wire logic                sendFin,
    input  wire logic                ackSegs,
    input  wire logic                failArp,
    input  wire logic                mute,
    input  wire logic                slow,
    input  wire logic                injFin,
    input  wire logic                injSyn,
    output var  scsf_pkg::scsf_net_t net
);
    import scsf_pkg::*;
    int   ackDly = 0;
    int   arpDly = 0;
    int   synDly = 0;
    int   finDly = 0;
    logic finArm = 1'b1;
    logic tick   = 1'b0;

    initial net = '0;

    always @(posedge clk)
    begin
        tick <= ~tick;
        // Slow peer stalls the wire every other cycle
        net.wireReady <= ~slow | tick;
        net.finIn     <= injFin;
        net.synIn     <= injSyn;
        if (!mute && (segValid && ackSegs || sendSynAck))
            ackDly <= slow ? 6 : 2;
        else if (ackDly > 0)
            ackDly <= ackDly - 1;
        if (!mute && arpRequest)
            arpDly <= 3;
        else if (arpDly > 0)
            arpDly <= arpDly - 1;
        if (!mute && sendSyn)
            synDly <= slow ? 7 : 3;
        else if (synDly > 0)
            synDly <= synDly - 1;
        // Answer a teardown only once per level, a stuck level must not re-ack
        if (!sendFin)
            finArm <= 1'b1;
        if (!mute && sendFin && finArm)
        begin
            finDly <= slow ? 8 : 4;
            finArm <= 1'b0;
        end
        else if (finDly > 0)
            finDly <= finDly - 1;
        net.ackIn    <= ackDly == 1 || finDly == 1;
        net.arpDone  <= arpDly == 1 && !failArp;
        net.arpFail  <= arpDly == 1 && failArp;
        net.synAckIn <= synDly == 1;
    end
endmodule // scsf_net_peer
`default_nettype wire

/* File: bench/scsf_socket_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scsf_params.svh"
module scsf_socket_tb_top;
    import scsf_pkg::*;
    logic        clk;
    logic        resetn;
    scsf_host_t  host;
    scsf_net_t   net;
    logic [15:0] retryPeriod;
    logic [7:0]  retryLimit;
    logic [7:0]  socketCommand;
    logic [7:0]  socketState;
    logic [7:0]  socketEventFlags;
    logic [15:0] txReadPointer;
    logic [15:0] txFreeSize;
    logic        sendSyn;
    logic        sendSynAck;
    logic        sendFin;
    logic        arpRequest;
    logic        segValid;
    logic [15:0] segLength;
    logic        ackSegs, failArp, mute, slow, injFin, injSyn;
    int          errors = 0;
    int          checked = 0;
    int          arpCnt = 0;
    int          synCnt = 0;
    int          synAckCnt = 0;
    int          n;
    logic [15:0] segQ[$];

    scsf_socket uut (.clk(clk), .resetn(resetn), .host(host), .net(net),
        .retryPeriod(retryPeriod), .retryLimit(retryLimit), .socketCommand(socketCommand),
        .socketState(socketState), .socketEventFlags(socketEventFlags),
        .txReadPointer(txReadPointer), .txFreeSize(txFreeSize), .sendSyn(sendSyn),
        .sendSynAck(sendSynAck), .sendFin(sendFin), .arpRequest(arpRequest),
        .segValid(segValid), .segLength(segLength));
    scsf_net_peer peer (.clk(clk), .segValid(segValid), .arpRequest(arpRequest),
        .sendSyn(sendSyn), .sendSynAck(sendSynAck), .sendFin(sendFin), .ackSegs(ackSegs),
        .failArp(failArp), .mute(mute), .slow(slow), .injFin(injFin), .injSyn(injSyn),
        .net(net));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    always @(posedge clk)
    begin
        if (segValid) segQ.push_back(segLength);
        if (arpRequest) arpCnt++;
        if (sendSyn) synCnt++;
        if (sendSynAck) synAckCnt++;
    end

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic issue(input logic [7:0] code);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        host.command   <= code;
        host.commandWe <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            host.commandWe <= 1'b0;
            #1;
            if (socketCommand === code) seen = 1'b1;
            if (seen && socketCommand === 8'h00) break;
        end
        chk(seen, 1'b1);
        chk(socketCommand, 8'h00);
    endtask

    task automatic waitSt(input logic [7:0] exp, input int lim);
        for (int i = 0; i < lim && socketState !== exp; i++)
            @(posedge clk) #1;
        #1;
        chk(socketState, exp);
    endtask

    task automatic waitFl(input logic [7:0] mask, input int lim);
        for (int i = 0; i < lim && (socketEventFlags & mask) !== mask; i++)
            @(posedge clk) #1;
        #1;
        chk(socketEventFlags & mask, mask);
    endtask

    task automatic clr(input logic [7:0] mask);
        @(posedge clk);
        host.eventClear <= mask;
        @(posedge clk);
        host.eventClear <= 8'h00;
        repeat (2) @(posedge clk);
        #1;
        chk(socketEventFlags & mask, 8'h00);
    endtask

    task automatic pulse(input logic fin);
        @(posedge clk);
        injFin <= fin;
        injSyn <= ~fin;
        @(posedge clk);
        injFin <= 1'b0;
        injSyn <= 1'b0;
    endtask

    task automatic open(input logic [3:0] proto, input logic [7:0] exp);
        @(posedge clk);
        host.protocol <= proto;
        issue(`SCSF_CMD_OPEN);
        waitSt(exp, 8);
    endtask

    // Model: bytes pending = write minus read pointer, cut into mss pieces
    task automatic sendData(input int add);
        int          total;
        int          rem;
        int          seg;
        logic [15:0] rp0;
        rp0   = txReadPointer;
        total = int'(16'(host.txWritePointer + add[15:0] - rp0));
        segQ.delete();
        @(posedge clk);
        host.txWritePointer <= host.txWritePointer + add[15:0];
        repeat (2) @(posedge clk);
        #1;
        chk(txFreeSize, 16'h0800 - total[15:0]);
        issue(`SCSF_CMD_SEND);
        waitFl(8'h10, 6000);
        rem = total;
        foreach (segQ[i])
        begin
            seg = rem < host.mss ? rem : int'(host.mss);
            chk(segQ[i], seg);
            rem -= seg;
        end
        chk(rem, 0);
        chk(txReadPointer, rp0 + total[15:0]);
        chk(txFreeSize, `SCSF_TX_SIZE);
        clr(8'h10);
    endtask

    // ==========================================
    // Watchdog
    // ==========================================
    initial
    begin
        repeat (80000) @(posedge clk);
        errors++;
        wrap_up;
    end

    // ==========================================
    // Main sequence
    // ==========================================
    initial
    begin
        host = '0;
        host.mss = 16'h0258;
        retryPeriod = 16'hFFFF;
        retryLimit = 8'hFF;
        resetn = 1'b0;
        {ackSegs, failArp, mute, slow, injFin, injSyn} = 6'b10_0000;
        n = $urandom(32'h2a97);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk(socketCommand, 8'h00);
        chk(socketState, `SCSF_ST_SHUT);
        chk(socketEventFlags, 8'h00);
        chk(txReadPointer, 16'h0000);
        chk(txFreeSize, `SCSF_TX_SIZE);
        open(`SCSF_PROTO_TCP, `SCSF_ST_OPENED);
        issue(`SCSF_CMD_LISTEN);
        waitSt(`SCSF_ST_AWAIT, 8);
        pulse(1'b0);
        waitSt(`SCSF_ST_HSRECV, 8);
        waitSt(`SCSF_ST_ESTAB, 30);
        chk(synAckCnt, 1);
        sendData(2048);
        slow <= 1'b1;
        sendData(600);
        slow <= 1'b0;
        repeat (3)
        begin
            @(posedge clk);
            host.mss <= 16'($urandom_range(600, 64));
            sendData($urandom_range(2048, 1));
        end
        pulse(1'b1);
        waitFl(8'h02, 20);
        waitSt(`SCSF_ST_PEERCLOSE, 4);
        repeat (10) @(posedge clk);
        chk(socketEventFlags & 8'h02, 8'h02);
        clr(8'h02);
        issue(`SCSF_CMD_TEARDOWN_COMMAND_OR_FLAG);
        chk(sendFin, 1'b1);
        waitSt(`SCSF_ST_SHUT, 100);
        chk(sendFin, 1'b0);
        waitFl(8'h02, 4);
        clr(8'hFF);
        issue(`SCSF_CMD_CLOSE);
        waitFl(8'h02, 8);
        clr(8'hFF);
        n = synCnt;
        open(`SCSF_PROTO_TCP, `SCSF_ST_OPENED);
        issue(`SCSF_CMD_CONNECT);
        waitSt(`SCSF_ST_ESTAB, 30);
        chk(synCnt, n + 1);
        chk(socketEventFlags & 8'h01, 8'h01);
        slow <= 1'b1;
        issue(`SCSF_CMD_TEARDOWN_COMMAND_OR_FLAG);
        waitSt(`SCSF_ST_SHUT, 100);
        slow <= 1'b0;
        clr(8'hFF);
        // Short retry settings so the final expiry fits the run
        @(posedge clk);
        retryPeriod <= 16'h0001;
        retryLimit <= 8'h00;
        mute <= 1'b1;
        open(`SCSF_PROTO_TCP, `SCSF_ST_OPENED);
        issue(`SCSF_CMD_CONNECT);
        for (n = 0; n < 30000 && socketEventFlags[`SCSF_EV_TIMEOUT] !== 1'b1; n++)
            @(posedge clk) #1;
        #1;
        chk(n > `SCSF_RETRY_UNIT_CYC - 100 && n < `SCSF_RETRY_UNIT_CYC + 100, 1'b1);
        chk(socketState, `SCSF_ST_SHUT);
        mute <= 1'b0;
        retryPeriod <= 16'hFFFF;
        retryLimit <= 8'hFF;
        clr(8'hFF);
        // Nothing is received here; a host polls received size, not a flag
        @(posedge clk);
        ackSegs <= 1'b0;
        failArp <= 1'b1;
        host.destIp <= 32'h0A00_0005;
        host.localIp <= $urandom;
        host.subnetMask <= 32'hFFFF_FF00;
        open(`SCSF_PROTO_UDP, `SCSF_ST_DGRAM);
        n = arpCnt;
        segQ.delete();
        @(posedge clk);
        host.txWritePointer <= host.txWritePointer + 16'h0040;
        issue(`SCSF_CMD_SEND);
        waitFl(8'h08, 50);
        chk(segQ.size(), 0);
        chk(arpCnt, n + 1);
        clr(8'h08);
        failArp <= 1'b0;
        sendData(0);
        chk(arpCnt, n + 2);
        @(posedge clk);
        host.destIp <= `SCSF_ALL_ONES_IP;
        n = arpCnt;
        sendData($urandom_range(2048, 1));
        @(posedge clk);
        host.destIp <= host.localIp | ~host.subnetMask;
        sendData($urandom_range(2048, 1));
        chk(arpCnt, n);
        clr(8'hFF);
        issue(`SCSF_CMD_CLOSE);
        waitSt(`SCSF_ST_SHUT, 8);
        wrap_up;
    end
endmodule // scsf_socket_tb_top
`default_nettype wire
